// ---- src/lsu_unit.sv ----
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// Function
// - AND writes dest AND source or memory word; nonzero from result, overflow cleared
// - AND literal changes low byte only; nonzero from byte, sign takes bit 7
// - OR writes dest OR source or memory; nonzero and sign follow result
// - Memory forms except bit test change only the destination, never the memory operand word
// - XOR writes dest XOR source or memory; nonzero and sign follow result
// - Word invert of source into dest; link cleared; sign is result top bit
// - Byte invert of source low byte into dest low byte; link cleared
// - Bit test ANDs operands without writing; nonzero and sign from AND
// - Rotate left through link by N up to 16 steps
// - Byte rotate left through link on the low 8 bits
// - Rotate right through link by N up to 16 steps
// - Byte rotate right through link; sign takes result bit 7
// - Logical shift left with zero fill, bit 15 into link each step
// - Byte logical shift left, bit 7 into link each step
// - Double shift left on the 32-bit pair, high word first
// - Pair starting at register 15 uses register 0 as low word
// - Count field bits 0 to 3 holds count modulo 16; zero means sixteen
// - Logical shift right, bit 0 into link, zero into bit 15
// - Circular right rotate leaves link unchanged; nonzero from original
// - Double shift right on the pair, low bit 0 into link
// - Arithmetic shift left sets overflow when link differs from bit 15
module lsu_unit #(
  parameter int unsigned NUM_REGS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  logic [15:0] regs [NUM_REGS];
  logic [15:0] mem_operand;
  lsu_pkg::lsu_cmd_t last_cmd;
  lsu_pkg::lsu_flags_t flags;
  logic bad_op;
  logic [4:0] exec_count;

  logic wr_en;
  logic setup;
  lsu_pkg::lsu_region_t wr_rgn;
  lsu_pkg::lsu_region_t rd_rgn;
  lsu_pkg::lsu_cmd_t cmd_in;
  logic exec;

  logic [15:0] dest_reg;
  logic [15:0] src_reg;
  logic [15:0] pair_low;
  logic [3:0] pair_idx;
  logic [7:0] immediate_byte;
  logic [4:0] steps;

  logic [15:0] next_dest;
  logic [15:0] next_low;
  logic next_dest_we;
  logic next_low_we;
  lsu_pkg::lsu_flags_t next_flags;
  logic next_bad;

  function automatic lsu_pkg::lsu_region_t decode_addr(input logic [7:0] a);
    lsu_pkg::lsu_region_t r;
    r = lsu_pkg::LSU_RGN_NONE;
    if (a[1:0] != 2'h0) begin
      r = lsu_pkg::LSU_RGN_NONE;
    end else if (a <= lsu_pkg::ADDR_REG_LAST) begin
      r = lsu_pkg::LSU_RGN_REG;
    end else if (a == lsu_pkg::ADDR_MEM_OPERAND) begin
      r = lsu_pkg::LSU_RGN_MEM;
    end else if (a == lsu_pkg::ADDR_COMMAND) begin
      r = lsu_pkg::LSU_RGN_CMD;
    end else if (a == lsu_pkg::ADDR_FLAGS) begin
      r = lsu_pkg::LSU_RGN_FLAGS;
    end else if (a == lsu_pkg::ADDR_STATUS) begin
      r = lsu_pkg::LSU_RGN_STATUS;
    end
    return r;
  endfunction : decode_addr

  function automatic logic is_known_op(input logic [4:0] op);
    return op <= lsu_pkg::LSU_OP_SHL_ARITH;
  endfunction : is_known_op

  // Zero-wait-state slave
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign wr_rgn = decode_addr(paddr);
  assign rd_rgn = wr_rgn;

  assign cmd_in.op = lsu_pkg::lsu_op_t'(pwdata[lsu_pkg::CMD_OP_LSB +: 5]);
  assign cmd_in.dest = pwdata[lsu_pkg::CMD_DEST_LSB +: 4];
  assign cmd_in.src = pwdata[lsu_pkg::CMD_SRC_LSB +: 4];
  assign cmd_in.count = pwdata[lsu_pkg::CMD_COUNT_LSB +: 4];
  assign exec = wr_en & (wr_rgn == lsu_pkg::LSU_RGN_CMD);

  // Operand fetch from the register file
  assign dest_reg = regs[cmd_in.dest];
  assign src_reg = regs[cmd_in.src];
  assign pair_idx = cmd_in.dest + 4'h1;
  assign pair_low = regs[pair_idx];
  assign immediate_byte = pwdata[lsu_pkg::CMD_IMM_LSB +: 8];
  // Count field modulo 16, zero encodes sixteen; a true zero count cannot occur
  assign steps = (cmd_in.count == 4'h0) ? lsu_pkg::COUNT_FULL : {1'b0, cmd_in.count};

  // Result and flags for the command in the write data
  always_comb begin
    logic [15:0] hi;
    logic [15:0] lo;
    logic lk;
    logic [15:0] conj;
    hi = dest_reg;
    lo = pair_low;
    lk = flags.link;
    conj = 16'h0000;
    next_dest = dest_reg;
    next_low = pair_low;
    next_dest_we = 1'b0;
    next_low_we = 1'b0;
    next_flags = flags;
    next_bad = 1'b0;
    case (cmd_in.op)
      lsu_pkg::LSU_OP_AND, lsu_pkg::LSU_OP_MEM_CONJ: begin
        next_dest = dest_reg & ((cmd_in.op == lsu_pkg::LSU_OP_AND) ? src_reg : mem_operand);
        next_dest_we = 1'b1;
        next_flags.nz = |next_dest;
        next_flags.ovf = 1'b0;
        next_flags.sign = next_dest[15];
      end
      lsu_pkg::LSU_OP_AND_LIT: begin
        next_dest = {dest_reg[15:8], dest_reg[7:0] & immediate_byte};
        next_dest_we = 1'b1;
        next_flags.nz = |next_dest[7:0];
        next_flags.sign = next_dest[7];
      end
      lsu_pkg::LSU_OP_OR, lsu_pkg::LSU_OP_OR_MEM: begin
        next_dest = dest_reg | ((cmd_in.op == lsu_pkg::LSU_OP_OR) ? src_reg : mem_operand);
        next_dest_we = 1'b1;
        next_flags.nz = |next_dest;
        next_flags.sign = next_dest[15];
      end
      lsu_pkg::LSU_OP_XOR, lsu_pkg::LSU_OP_XOR_MEM: begin
        next_dest = dest_reg ^ ((cmd_in.op == lsu_pkg::LSU_OP_XOR) ? src_reg : mem_operand);
        next_dest_we = 1'b1;
        next_flags.nz = |next_dest;
        next_flags.sign = next_dest[15];
      end
      lsu_pkg::LSU_OP_INVERT_WORD: begin
        next_dest = ~src_reg;
        next_dest_we = 1'b1;
        next_flags.nz = (src_reg != 16'hffff);
        next_flags.link = 1'b0;
        next_flags.sign = next_dest[15];
      end
      lsu_pkg::LSU_OP_INVERT_BYTE: begin
        next_dest = {dest_reg[15:8], ~src_reg[7:0]};
        next_dest_we = 1'b1;
        next_flags.nz = (src_reg[7:0] != 8'hff);
        next_flags.link = 1'b0;
        next_flags.sign = next_dest[7];
      end
      lsu_pkg::LSU_OP_BIT_TEST, lsu_pkg::LSU_OP_BIT_TEST_MEM: begin
        conj = dest_reg & ((cmd_in.op == lsu_pkg::LSU_OP_BIT_TEST) ? src_reg : mem_operand);
        next_flags.nz = |conj;
        next_flags.sign = conj[15];
      end
      lsu_pkg::LSU_OP_ROT_LEFT_CARRY, lsu_pkg::LSU_OP_ROT_LEFT_CARRY_BYTE,
      lsu_pkg::LSU_OP_ROT_RIGHT_CARRY, lsu_pkg::LSU_OP_ROT_RIGHT_CARRY_BYTE,
      lsu_pkg::LSU_OP_SHL_ZERO, lsu_pkg::LSU_OP_SHL_ZERO_BYTE, lsu_pkg::LSU_OP_SHL_ARITH,
      lsu_pkg::LSU_OP_SHL_DOUBLE, lsu_pkg::LSU_OP_SHR_ZERO, lsu_pkg::LSU_OP_ROT_RIGHT_CIRC,
      lsu_pkg::LSU_OP_SHR_DOUBLE: begin
        // One pass per step; the link is taken before the word moves
        for (int i = 0; i < lsu_pkg::MAX_STEPS; i++) begin
          if (5'(i) < steps) begin
            case (cmd_in.op)
              lsu_pkg::LSU_OP_ROT_LEFT_CARRY: begin
                {lk, hi} = {hi, lk};
              end
              lsu_pkg::LSU_OP_ROT_LEFT_CARRY_BYTE: begin
                {lk, hi[7:0]} = {hi[7:0], lk};
              end
              lsu_pkg::LSU_OP_ROT_RIGHT_CARRY: begin
                {hi, lk} = {lk, hi};
              end
              lsu_pkg::LSU_OP_ROT_RIGHT_CARRY_BYTE: begin
                {hi[7:0], lk} = {lk, hi[7:0]};
              end
              lsu_pkg::LSU_OP_SHL_ZERO, lsu_pkg::LSU_OP_SHL_ARITH: begin
                {lk, hi} = {hi, 1'b0};
              end
              lsu_pkg::LSU_OP_SHL_ZERO_BYTE: begin
                {lk, hi[7:0]} = {hi[7:0], 1'b0};
              end
              lsu_pkg::LSU_OP_SHL_DOUBLE: begin
                {lk, hi, lo} = {hi, lo, 1'b0};
              end
              lsu_pkg::LSU_OP_SHR_ZERO: begin
                {hi, lk} = {1'b0, hi};
              end
              lsu_pkg::LSU_OP_ROT_RIGHT_CIRC: begin
                hi = {hi[0], hi[15:1]};
              end
              lsu_pkg::LSU_OP_SHR_DOUBLE: begin
                {hi, lo, lk} = {1'b0, hi, lo};
              end
              default: begin
                hi = hi;
              end
            endcase
          end
        end
        next_dest = hi;
        next_dest_we = 1'b1;
        next_flags.link = lk;
        case (cmd_in.op)
          lsu_pkg::LSU_OP_ROT_LEFT_CARRY_BYTE, lsu_pkg::LSU_OP_ROT_RIGHT_CARRY_BYTE,
          lsu_pkg::LSU_OP_SHL_ZERO_BYTE: begin
            next_flags.nz = |hi[7:0];
            next_flags.sign = hi[7];
          end
          lsu_pkg::LSU_OP_SHL_DOUBLE, lsu_pkg::LSU_OP_SHR_DOUBLE: begin
            next_low = lo;
            next_low_we = 1'b1;
            next_flags.nz = |{hi, lo};
            next_flags.sign = hi[15];
          end
          lsu_pkg::LSU_OP_ROT_RIGHT_CIRC: begin
            next_flags.nz = |dest_reg;
            next_flags.sign = hi[15];
          end
          lsu_pkg::LSU_OP_SHL_ARITH: begin
            next_flags.nz = |hi;
            next_flags.sign = hi[15];
            next_flags.ovf = lk ^ hi[15];
          end
          default: begin
            next_flags.nz = |hi;
            next_flags.sign = hi[15];
          end
        endcase
      end
      default: begin
        next_bad = 1'b1;
      end
    endcase
  end

  // Register file: software writes and instruction results
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_regs
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs[g] <= lsu_pkg::REG_RESET;
        end else if (exec && next_dest_we && cmd_in.dest == 4'(g)) begin
          regs[g] <= next_dest;
        end else if (exec && next_low_we && pair_idx == 4'(g)) begin
          regs[g] <= next_low;
        end else if (wr_en && wr_rgn == lsu_pkg::LSU_RGN_REG && paddr[5:2] == 4'(g)) begin
          regs[g] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  // Memory operand word, written only by software writes at ADDR_MEM_OPERAND
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_operand <= lsu_pkg::REG_RESET;
    end else if (wr_en && wr_rgn == lsu_pkg::LSU_RGN_MEM) begin
      mem_operand <= pwdata[15:0];
    end
  end

  // Last accepted command, read back in the command word layout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cmd <= lsu_pkg::lsu_cmd_t'(17'(lsu_pkg::CMD_RESET));
    end else if (exec) begin
      last_cmd <= cmd_in;
    end
  end

  // Condition flags; an executed command wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else if (exec) begin
      flags <= next_flags;
    end else if (wr_en && wr_rgn == lsu_pkg::LSU_RGN_FLAGS) begin
      flags <= pwdata[lsu_pkg::FLAGS_W-1:0];
    end
  end

  // Sticky unknown-opcode bit; a new error wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_op <= 1'b0;
    end else if (exec && next_bad) begin
      bad_op <= 1'b1;
    end else if (wr_en && wr_rgn == lsu_pkg::LSU_RGN_STATUS && pwdata[0]) begin
      bad_op <= 1'b0;
    end
  end

  // Step count of the last known command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_count <= 5'h00;
    end else if (exec && is_known_op(cmd_in.op)) begin
      exec_count <= steps;
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= (rd_rgn == lsu_pkg::LSU_RGN_NONE);
      case (rd_rgn)
        lsu_pkg::LSU_RGN_REG: prdata <= {16'h0000, regs[paddr[5:2]]};
        lsu_pkg::LSU_RGN_MEM: prdata <= {16'h0000, mem_operand};
        lsu_pkg::LSU_RGN_CMD: begin
          prdata <= {11'h0, last_cmd.op, 4'h0, last_cmd.dest, last_cmd.src, last_cmd.count};
        end
        lsu_pkg::LSU_RGN_FLAGS: prdata <= {28'h0000000, flags};
        lsu_pkg::LSU_RGN_STATUS: prdata <= {26'h0, exec_count, bad_op};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule : lsu_unit

// ---- include/lsu_pkg.sv ----
package lsu_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned APB_AW = 8;

  // Byte addresses on the APB
  localparam logic [7:0] ADDR_REG_BASE = 8'h00;
  localparam logic [7:0] ADDR_REG_LAST = 8'h3c;
  localparam logic [7:0] ADDR_MEM_OPERAND = 8'h40;
  localparam logic [7:0] ADDR_COMMAND = 8'h44;
  localparam logic [7:0] ADDR_FLAGS = 8'h48;
  localparam logic [7:0] ADDR_STATUS = 8'h4c;

  // Command word fields
  localparam int unsigned CMD_COUNT_LSB = 0;
  localparam int unsigned CMD_SRC_LSB = 4;
  localparam int unsigned CMD_IMM_LSB = 0;
  localparam int unsigned CMD_DEST_LSB = 8;
  localparam int unsigned CMD_OP_LSB = 16;
  localparam int unsigned CMD_USED_W = 21;
  localparam int unsigned FLAGS_W = 4;
  localparam int unsigned STATUS_W = 6;

  // Reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [20:0] CMD_RESET = 21'h00000;

  // Full count used when the count field holds zero
  localparam logic [4:0] COUNT_FULL = 5'h10;
  localparam int unsigned MAX_STEPS = 16;

  typedef enum logic [4:0] {
    LSU_OP_AND = 5'h00,
    LSU_OP_MEM_CONJ = 5'h01,
    LSU_OP_AND_LIT = 5'h02,
    LSU_OP_OR = 5'h03,
    LSU_OP_OR_MEM = 5'h04,
    LSU_OP_XOR = 5'h05,
    LSU_OP_XOR_MEM = 5'h06,
    LSU_OP_INVERT_WORD = 5'h07,
    LSU_OP_INVERT_BYTE = 5'h08,
    LSU_OP_BIT_TEST = 5'h09,
    LSU_OP_BIT_TEST_MEM = 5'h0a,
    LSU_OP_ROT_LEFT_CARRY = 5'h0b,
    LSU_OP_ROT_LEFT_CARRY_BYTE = 5'h0c,
    LSU_OP_ROT_RIGHT_CARRY = 5'h0d,
    LSU_OP_ROT_RIGHT_CARRY_BYTE = 5'h0e,
    LSU_OP_SHL_ZERO = 5'h0f,
    LSU_OP_SHL_ZERO_BYTE = 5'h10,
    LSU_OP_SHL_DOUBLE = 5'h11,
    LSU_OP_SHR_ZERO = 5'h12,
    LSU_OP_ROT_RIGHT_CIRC = 5'h13,
    LSU_OP_SHR_DOUBLE = 5'h14,
    LSU_OP_SHL_ARITH = 5'h15
  } lsu_op_t;

  typedef struct packed {
    logic sign;
    logic link;
    logic ovf;
    logic nz;
  } lsu_flags_t;

  typedef struct packed {
    lsu_op_t op;
    logic [3:0] dest;
    logic [3:0] src;
    logic [3:0] count;
  } lsu_cmd_t;

  typedef enum logic [2:0] {
    LSU_RGN_REG = 3'h0,
    LSU_RGN_MEM = 3'h1,
    LSU_RGN_CMD = 3'h2,
    LSU_RGN_FLAGS = 3'h3,
    LSU_RGN_STATUS = 3'h4,
    LSU_RGN_NONE = 3'h7
  } lsu_region_t;

endpackage : lsu_pkg

// ---- verif/lsu_unit_props.sv ----
`timescale 1ns/10ps
module lsu_chk #(
  parameter int unsigned NUM_REGS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic setup;
  logic rd;
  logic mapped;
  logic [15:0] mem_w;
  logic [4:0] last_n;
  logic last_shift;
  assign setup = psel && !penable;
  assign rd = setup && !pwrite;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= 8'h4c;
  // Shadow of the memory word and of the last command's step count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_w <= 16'h0000;
      last_n <= 5'h00;
      last_shift <= 1'b0;
    end else if (psel && penable && pwrite && pready) begin
      if (paddr == 8'h40) begin
        mem_w <= pwdata[15:0];
      end
      if (paddr == 8'h44) begin
        last_shift <= pwdata[20:16] >= 5'h0b && pwdata[20:16] <= 5'h15;
        last_n <= (pwdata[3:0] == 4'h0) ? 5'h10 : {1'b0, pwdata[3:0]};
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  property p_err; setup && !mapped |=> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("no error on bad address");
  property p_ok; setup && mapped |=> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("error on good address");
  property p_hold; !setup |=> $stable(prdata) && $stable(pslverr); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_regw; rd && paddr <= 8'h3c |=> prdata[31:16] == 16'h0; endproperty
  a_regw: assert property (p_regw) else $error("register upper bits set");
  property p_mem; rd && paddr == 8'h40 |=> prdata[15:0] == mem_w; endproperty
  a_mem: assert property (p_mem) else $error("memory word changed");
  property p_flags; rd && paddr == 8'h48 |=> prdata[31:4] == 28'h0; endproperty
  a_flags: assert property (p_flags) else $error("flags upper bits set");
  property p_status; rd && paddr == 8'h4c && last_shift |=> prdata[5:1] == last_n; endproperty
  a_status: assert property (p_status) else $error("step count wrong");
  c_err: cover property (setup && !mapped);
  c_cmd: cover property (psel && penable && pwrite && paddr == 8'h44);
  c_status: cover property (rd && paddr == 8'h4c && last_shift);
endmodule : lsu_chk

bind lsu_unit lsu_chk #(.NUM_REGS(NUM_REGS)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// ---- verif/lsu_opnd_src.sv ----
`timescale 1ns/10ps
// Memory path: whole 16-bit words, a new one each cycle, no write-back
module lsu_opnd_src (
  input wire logic pclk,
  input wire logic presetn,
  output logic [15:0] word
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word <= 16'h8001;
    end else begin
      word <= {word[14:0], word[15] ^ word[13] ^ word[12] ^ word[10]};
    end
  end
endmodule : lsu_opnd_src

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] mem_word;
  logic [15:0] regs [16];
  logic [31:0] seed = 32'h00000031;
  int fails = 0;
  int compares = 0;
  lsu_unit #(.NUM_REGS(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  lsu_opnd_src u_src (.pclk(pclk), .presetn(presetn), .word(mem_word));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic give_verdict();
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s %h vs %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    if (pready !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask : xfer
  task automatic wreg(input logic [3:0] i, input logic [15:0] v);
    logic [31:0] q;
    xfer(1'b1, {2'h0, i, 2'h0}, {16'h0, v}, q);
    regs[i] = v;
  endtask : wreg
  function automatic logic [35:0] model(input logic [4:0] op, input logic [15:0] a,
      input logic [15:0] a2, input logic [15:0] b, input logic [7:0] imm,
      input lsu_pkg::lsu_flags_t f);
    logic [15:0] r;
    logic [15:0] r2;
    logic lk;
    int n;
    r = a;
    r2 = a2;
    lk = f.link;
    n = (imm[3:0] == 4'h0) ? 16 : int'(imm[3:0]);
    case (op)
      5'h00, 5'h01: r = a & b;
      5'h02: r[7:0] = a[7:0] & imm;
      5'h03, 5'h04: r = a | b;
      5'h05, 5'h06: r = a ^ b;
      5'h07: r = ~b;
      5'h08: r[7:0] = ~b[7:0];
      default: ;
    endcase
    for (int i = 0; i < n && op > 5'h0a; i++) begin
      case (op)
        5'h0b: {lk, r} = {r, lk};
        5'h0c: {lk, r[7:0]} = {r[7:0], lk};
        5'h0d: {r, lk} = {lk, r};
        5'h0e: {r[7:0], lk} = {lk, r[7:0]};
        5'h0f, 5'h15: {lk, r} = {r, 1'b0};
        5'h10: {lk, r[7:0]} = {r[7:0], 1'b0};
        5'h11: {lk, r, r2} = {r, r2, 1'b0};
        5'h12: {r, lk} = {1'b0, r};
        5'h13: r = {r[0], r[15:1]};
        default: {r, r2, lk} = {1'b0, r, r2};
      endcase
    end
    f.nz = |r;
    f.sign = r[15];
    if (op inside {5'h02, 5'h08, 5'h0c, 5'h0e, 5'h10}) begin
      f.nz = |r[7:0];
      f.sign = r[7];
    end
    if (op == 5'h09 || op == 5'h0a) begin
      f.nz = |(a & b);
      f.sign = a[15] & b[15];
    end
    if (op == 5'h11 || op == 5'h14) f.nz = |{r, r2};
    if (op == 5'h13) f.nz = |a;
    if (op < 5'h02) f.ovf = 1'b0;
    if (op == 5'h15) f.ovf = lk ^ r[15];
    if (op == 5'h07 || op == 5'h08) lk = 1'b0;
    f.link = lk;
    return {r, r2, f};
  endfunction : model
  initial begin
    logic [31:0] q;
    logic [35:0] e;
    logic [4:0] op;
    logic [3:0] d;
    logic [3:0] fl;
    logic [7:0] imm;
    logic [15:0] m;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0, q);
    check(q, 32'h0, "reg reset");
    xfer(1'b0, 8'h48, 32'h0, q);
    check(q, 32'h0, "flags reset");
    xfer(1'b0, 8'h50, 32'h0, q);
    check({q[31:1], pslverr}, 32'h1, "unmapped");
    xfer(1'b1, 8'h41, 32'hffff, q);
    check({31'h0, pslverr}, 32'h1, "misaligned");
    for (int k = 0; k < 88; k++) begin
      op = 5'(k % 22);
      q = rnd();
      d = (k < 22) ? 4'hf : q[11:8];
      // Count field zero encodes sixteen steps, never a zero shift
      imm = (k >= 22 && k < 44) ? {q[7:4], 4'h0} : q[7:0];
      fl = q[15:12];
      wreg(d, q[31:16]);
      q = rnd();
      wreg(d + 4'h1, q[15:0]);
      wreg(imm[7:4], q[31:16]);
      m = mem_word;
      xfer(1'b1, 8'h40, {16'h0, m}, q);
      xfer(1'b1, 8'h48, {28'h0, fl}, q);
      e = model(op, regs[d], regs[d + 4'h1],
        (op inside {5'h01, 5'h04, 5'h06, 5'h0a}) ? m : regs[imm[7:4]], imm, fl);
      xfer(1'b1, 8'h44, {11'h0, op, 4'h0, d, imm}, q);
      xfer(1'b0, {2'h0, d, 2'h0}, 32'h0, q);
      check(q, {16'h0, e[35:20]}, "dest");
      xfer(1'b0, {2'h0, d + 4'h1, 2'h0}, 32'h0, q);
      check(q, {16'h0, e[19:4]}, "pair");
      xfer(1'b0, 8'h48, 32'h0, q);
      check(q, {28'h0, e[3:0]}, "flags");
      xfer(1'b0, 8'h44, 32'h0, q);
      check(q, {11'h0, op, 4'h0, d, imm}, "command");
      xfer(1'b0, 8'h4c, 32'h0, q);
      check(q, {26'h0, (imm[3:0] == 4'h0) ? 5'h10 : {1'b0, imm[3:0]}, 1'b0}, "steps");
      xfer(1'b0, 8'h40, 32'h0, q);
      check(q, {16'h0, m}, "memory word");
      regs[d] = e[35:20];
      regs[d + 4'h1] = e[19:4];
    end
    xfer(1'b1, 8'h44, {11'h0, 5'h1f, 4'h0, d, 8'h00}, q);
    xfer(1'b0, 8'h4c, 32'h0, q);
    check({31'h0, q[0]}, 32'h1, "bad opcode");
    xfer(1'b0, {2'h0, d, 2'h0}, 32'h0, q);
    check(q, {16'h0, regs[d]}, "bad opcode dest");
    xfer(1'b1, 8'h4c, 32'h1, q);
    xfer(1'b0, 8'h4c, 32'h0, q);
    check({31'h0, q[0]}, 32'h0, "sticky clear");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    give_verdict();
  end
endmodule : testbench
